// *** hw/smx_cfg.svh ***
`ifndef SMX_CFG_SVH
`define SMX_CFG_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define SMX_REG_CMD_LAST 8'h3C
`define SMX_REG_CTRL 8'h40
`define SMX_REG_STAT 8'h44
`define SMX_REG_IRQ_STAT 8'h48
`define SMX_REG_IRQ_MASK 8'h4C
`define SMX_REG_MEM_ADDR 8'h50
`define SMX_REG_MEM_DATA 8'h54
`define SMX_CTRL_GO 0
`define SMX_STAT_BUSY 0
`define SMX_STAT_ERR 1
`define SMX_STAT_RTS 2
`define SMX_IRQ_DONE 0
`define SMX_IRQ_ERR 1

// ----------------------------------------
// command block values
// ----------------------------------------
`define SMX_CODE_CREATE 16'h0001
`define SMX_CODE_CLOSE 16'h0002
`define SMX_CODE_XCHG 16'h0203
`define SMX_PROTO_SLAVE 16'h0023
`define SMX_CONN_MIN 16'h4B15
`define SMX_CONN_MAX 16'h4B63
`define SMX_WCNT_MAX 16'h00FE
`define SMX_RCNT_MAX 16'h0100
`define SMX_TMO_FOREVER 16'h03E7
`define SMX_HS_MODEM 16'h0006
`define SMX_PEER_BITS 16'h0007
`define SMX_PEER_PARITY 16'h0001
`define SMX_PEER_STOP 16'h0001

// ----------------------------------------
// error codes written to word 0
// ----------------------------------------
`define SMX_ERR_CODE 16'h0001
`define SMX_ERR_COUNT 16'h0002
`define SMX_ERR_PORT 16'h0003
`define SMX_ERR_CONN 16'h0004
`define SMX_ERR_PARAM 16'h0005
`define SMX_ERR_TMO 16'h0006
`define SMX_ERR_REPLY 16'h0007

// ----------------------------------------
// timing
// ----------------------------------------
`define SMX_CLK_HZ 100000000
`define SMX_TMO_DEF_S 16'h0009

`endif

// *** hw/smx_pkg.sv ***
package smx_pkg;

  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_DECODE = 3'b001,
    S_SEND = 3'b011,
    S_WAIT = 3'b010,
    S_COPY = 3'b110,
    S_DONE = 3'b100
  } smx_state_t;

endpackage : smx_pkg

// *** hw/smx_tmo.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smx_cfg.svh"

module smx_tmo #(
  parameter int CYC_PER_SEC = `SMX_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic run,
  input wire logic no_limit,
  input wire logic [15:0] secs,
  output logic expired
);

  logic [31:0] pre;
  logic [15:0] sec_cnt;

  // saturating seconds count, so a long wait never wraps into a false expiry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= 32'h0000_0000;
      sec_cnt <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        pre <= 32'h0000_0000;
        sec_cnt <= 16'h0000;
      end
      else if (run)
      begin
        if (pre == 32'(CYC_PER_SEC - 1))
        begin
          pre <= 32'h0000_0000;
          if (sec_cnt != 16'hFFFF)
            sec_cnt <= sec_cnt + 16'h0001;
        end
        else
          pre <= pre + 32'h0000_0001;
      end
    end
  end

  assign expired = run & ~no_limit & (sec_cnt >= secs);

endmodule : smx_tmo
`default_nettype wire

// *** hw/smx_top.sv ***
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "smx_cfg.svh"

module smx_top #(
  parameter int MEM_AW = 8,
  parameter int CYC_PER_SEC = `SMX_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] host_select_setting,
  output logic tx_valid,
  output logic [15:0] tx_data,
  input wire logic tx_ready,
  output logic [1:0] tx_port,
  output logic [15:0] tx_baud,
  output logic rts,
  input wire logic cts,
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_bad,
  output logic irq
);

  logic [15:0] cmd [16];
  logic [15:0] lmem [2**MEM_AW];
  logic [15:0] stage [256];
  smx_pkg::smx_state_t state;
  logic cts_m, cts_s;
  logic [3:0] hsel_m, hsel_s;
  logic [3:0] conn_used, conn_modem;
  logic [15:0] conn_num [4];
  logic [15:0] conn_baud [4];
  logic [1:0] irq_stat, irq_mask, irq_set;
  logic [MEM_AW-1:0] mem_ptr;
  logic [8:0] tx_idx, rx_cnt, cp_idx;
  logic [15:0] err_code, dec_err;
  logic err_flag, act_modem, rx_err, rd_vld, tmo_hit, tx_fire, busy;
  logic wr_en, rd_done, mapped;
  logic [2:0] conn_hit;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] find_conn(input logic [15:0] num);
    logic [2:0] r;
    r = 3'b000;
    for (int i = 0; i < 4; i++)
      if (conn_used[i] && conn_num[i] == num)
        r = {1'b1, 2'(i)};
    return r;
  endfunction : find_conn

  function automatic logic baud_ok(input logic [15:0] b);
    return b == 16'h012C || b == 16'h0258 || b == 16'h04B0 || b == 16'h0960 ||
           b == 16'h12C0 || b == 16'h2580 || b == 16'h4B00;
  endfunction : baud_ok

  function automatic logic [15:0] word_at(input logic [8:0] idx);
    unique case (idx)
      9'h000: return `SMX_CODE_XCHG;
      9'h001: return cmd[5];
      9'h002: return cmd[4];
      9'h003: return cmd[7];
      9'h004: return cmd[8];
      default: return lmem[MEM_AW'(cmd[3] + 16'(idx - 9'h005))];
    endcase
  endfunction : word_at

  // slot holding the connection named in word 2, bit 2 set on a hit
  always_comb conn_hit = find_conn(cmd[2]);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cts_m <= 1'b0;
      cts_s <= 1'b0;
      hsel_m <= 4'h0;
      hsel_s <= 4'h0;
    end
    else if (clk_en)
    begin
      cts_m <= cts;
      cts_s <= cts_m;
      hsel_m <= host_select_setting;
      hsel_s <= hsel_m;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // reads take one extra access cycle so prdata comes from a flop
  assign busy = state != smx_pkg::S_IDLE;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= `SMX_REG_MEM_DATA;
  assign pready = psel & penable & clk_en & (pwrite | rd_vld);
  assign pslverr = pready & ~mapped;
  assign wr_en = pready & pwrite & mapped;
  assign rd_done = pready & ~pwrite & mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_vld <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      rd_vld <= psel & penable & ~pwrite & ~rd_vld;
      if (psel & penable & ~pwrite & ~rd_vld)
      begin
        prdata <= 32'h0000_0000;
        if (paddr <= `SMX_REG_CMD_LAST)
          prdata[15:0] <= cmd[paddr[5:2]];
        else if (paddr == `SMX_REG_STAT)
          prdata[2:0] <= {rts, err_flag, busy};
        else if (paddr == `SMX_REG_IRQ_STAT)
          prdata[1:0] <= irq_stat;
        else if (paddr == `SMX_REG_IRQ_MASK)
          prdata[1:0] <= irq_mask;
        else if (paddr == `SMX_REG_MEM_ADDR)
          prdata[MEM_AW-1:0] <= mem_ptr;
        else if (paddr == `SMX_REG_MEM_DATA)
          prdata[15:0] <= lmem[mem_ptr];
      end
    end
  end

  // host writes to the block are locked out while a command runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
        cmd[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (wr_en && !busy && paddr <= `SMX_REG_CMD_LAST)
        cmd[paddr[5:2]] <= pwdata[15:0];
      else if (state == smx_pkg::S_DONE && err_code != 16'h0000)
        cmd[0] <= err_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_ptr <= '0;
    else if (clk_en && !busy)
    begin
      if (wr_en && paddr == `SMX_REG_MEM_ADDR)
        mem_ptr <= pwdata[MEM_AW-1:0];
      else if ((wr_en || rd_done) && paddr == `SMX_REG_MEM_DATA)
        mem_ptr <= mem_ptr + MEM_AW'(1);
    end
  end

  // copy-back wins: the host port is idle-only anyway
  always_ff @(posedge pclk)
  begin
    if (clk_en)
    begin
      if (state == smx_pkg::S_COPY)
        lmem[MEM_AW'(cmd[9] + 16'(cp_idx))] <= stage[cp_idx[7:0]];
      else if (wr_en && !busy && paddr == `SMX_REG_MEM_DATA)
        lmem[mem_ptr] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk)
  begin
    if (clk_en && state == smx_pkg::S_WAIT && rx_valid && rx_cnt < cmd[8][8:0])
      stage[rx_cnt[7:0]] <= rx_data;
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign irq_set = {state == smx_pkg::S_DONE && err_code != 16'h0000, state == smx_pkg::S_DONE};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end
    else if (clk_en)
    begin
      if (wr_en && paddr == `SMX_REG_IRQ_MASK)
        irq_mask <= pwdata[1:0];
      if (rd_done && paddr == `SMX_REG_IRQ_STAT)
        irq_stat <= irq_set;
      else
        irq_stat <= irq_stat | irq_set;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb
  begin
    logic [2:0] hit;
    logic [1:0] p;
    hit = find_conn(cmd[2]);
    p = 2'(cmd[4] - 16'h0001);
    dec_err = 16'h0000;
    unique case (cmd[1])
      `SMX_CODE_XCHG:
      begin
        if (cmd[4] == 16'h0000 || cmd[4] > `SMX_WCNT_MAX)
          dec_err = `SMX_ERR_COUNT;
        else if (cmd[8] == 16'h0000 || cmd[8] > `SMX_RCNT_MAX)
          dec_err = `SMX_ERR_COUNT;
        else if (!hit[2])
          dec_err = `SMX_ERR_CONN;
      end
      `SMX_CODE_CREATE:
      begin
        if (cmd[3] != `SMX_PROTO_SLAVE)
          dec_err = `SMX_ERR_PARAM;
        else if (cmd[2] < `SMX_CONN_MIN || cmd[2] > `SMX_CONN_MAX || hit[2])
          dec_err = `SMX_ERR_CONN;
        else if (cmd[4] == 16'h0000 || cmd[4] > 16'h0004 || !hsel_s[p] || conn_used[p])
          dec_err = `SMX_ERR_PORT;
        else if (!baud_ok(cmd[5]))
          dec_err = `SMX_ERR_PARAM;
        // peer protocol admits only one legal character format
        else if (cmd[6] != `SMX_PEER_BITS || cmd[7] != `SMX_PEER_PARITY || cmd[8] != `SMX_PEER_STOP)
          dec_err = `SMX_ERR_PARAM;
        else if (cmd[9] > 16'h0002 && cmd[9] != `SMX_HS_MODEM)
          dec_err = `SMX_ERR_PARAM;
      end
      `SMX_CODE_CLOSE:
      begin
        if (!hit[2])
          dec_err = `SMX_ERR_CONN;
      end
      default: dec_err = `SMX_ERR_CODE;
    endcase
  end

  // ----------------------------------------
  // connection table
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conn_used <= 4'h0;
      conn_modem <= 4'h0;
      for (int i = 0; i < 4; i++)
      begin
        conn_num[i] <= 16'h0000;
        conn_baud[i] <= 16'h0000;
      end
    end
    else if (clk_en && state == smx_pkg::S_DECODE && dec_err == 16'h0000)
    begin
      if (cmd[1] == `SMX_CODE_CREATE)
      begin
        conn_used[2'(cmd[4] - 16'h0001)] <= 1'b1;
        conn_num[2'(cmd[4] - 16'h0001)] <= cmd[2];
        conn_baud[2'(cmd[4] - 16'h0001)] <= cmd[5];
        conn_modem[2'(cmd[4] - 16'h0001)] <= cmd[9] == `SMX_HS_MODEM;
      end
      else if (cmd[1] == `SMX_CODE_CLOSE)
        conn_used[conn_hit[1:0]] <= 1'b0;
    end
  end

  // ----------------------------------------
  // exchange sequencer
  // ----------------------------------------
  assign tx_valid = state == smx_pkg::S_SEND && (!act_modem || cts_s);
  assign rts = state == smx_pkg::S_SEND && act_modem;
  assign tx_fire = tx_valid & tx_ready;

  smx_tmo #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_tmo (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(state == smx_pkg::S_DECODE),
    .run(state == smx_pkg::S_SEND || state == smx_pkg::S_WAIT),
    .no_limit(cmd[6] == `SMX_TMO_FOREVER),
    .secs(cmd[6] == 16'h0000 ? `SMX_TMO_DEF_S : cmd[6]),
    .expired(tmo_hit)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= smx_pkg::S_IDLE;
      err_code <= 16'h0000;
      err_flag <= 1'b0;
      act_modem <= 1'b0;
      tx_port <= 2'h0;
      tx_baud <= 16'h0000;
      tx_data <= 16'h0000;
      tx_idx <= 9'h000;
      rx_cnt <= 9'h000;
      rx_err <= 1'b0;
      cp_idx <= 9'h000;
    end
    else if (clk_en)
    begin
      unique case (state)
        smx_pkg::S_IDLE:
        begin
          if (wr_en && paddr == `SMX_REG_CTRL && pwdata[`SMX_CTRL_GO])
          begin
            state <= smx_pkg::S_DECODE;
            err_code <= 16'h0000;
            err_flag <= 1'b0;
          end
        end
        smx_pkg::S_DECODE:
        begin
          err_code <= dec_err;
          tx_idx <= 9'h000;
          rx_cnt <= 9'h000;
          rx_err <= 1'b0;
          tx_data <= word_at(9'h000);
          tx_port <= conn_hit[1:0];
          act_modem <= conn_modem[conn_hit[1:0]];
          tx_baud <= conn_baud[conn_hit[1:0]];
          if (dec_err == 16'h0000 && cmd[1] == `SMX_CODE_XCHG)
            state <= smx_pkg::S_SEND;
          else
            state <= smx_pkg::S_DONE;
        end
        smx_pkg::S_SEND:
        begin
          if (tmo_hit)
          begin
            err_code <= `SMX_ERR_TMO;
            state <= smx_pkg::S_DONE;
          end
          else if (tx_fire)
          begin
            tx_idx <= tx_idx + 9'h001;
            tx_data <= word_at(tx_idx + 9'h001);
            if (tx_idx == cmd[4][8:0] + 9'h004)
              state <= smx_pkg::S_WAIT;
          end
        end
        smx_pkg::S_WAIT:
        begin
          if (rx_valid)
          begin
            rx_cnt <= rx_cnt + 9'h001;
            if (rx_last)
            begin
              // count must match exactly before anything lands in local memory
              if (rx_err || rx_bad || rx_cnt + 9'h001 != cmd[8][8:0])
              begin
                err_code <= `SMX_ERR_REPLY;
                state <= smx_pkg::S_DONE;
              end
              else
              begin
                cp_idx <= 9'h000;
                state <= smx_pkg::S_COPY;
              end
            end
            else if (rx_bad || rx_cnt >= cmd[8][8:0])
              rx_err <= 1'b1;
          end
          else if (tmo_hit)
          begin
            err_code <= `SMX_ERR_TMO;
            state <= smx_pkg::S_DONE;
          end
        end
        smx_pkg::S_COPY:
        begin
          cp_idx <= cp_idx + 9'h001;
          if (cp_idx == cmd[8][8:0] - 9'h001)
            state <= smx_pkg::S_DONE;
        end
        smx_pkg::S_DONE:
        begin
          err_flag <= err_code != 16'h0000;
          state <= smx_pkg::S_IDLE;
        end
        default: state <= smx_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_tx_cts_gate: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && act_modem |-> cts_s && rts) else $error("word offered without cts");
  a_rts_holds: assert property (@(posedge pclk) disable iff (!presetn)
    rts && !tx_fire && !tmo_hit && clk_en |=> rts) else $error("rts dropped before send");
  a_bad_code: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == smx_pkg::S_DECODE && cmd[1] != `SMX_CODE_XCHG && cmd[1] != `SMX_CODE_CREATE
    && cmd[1] != `SMX_CODE_CLOSE |=> state == smx_pkg::S_DONE && err_code == `SMX_ERR_CODE)
    else $error("unknown code not rejected");
  a_wcnt_range: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == smx_pkg::S_DECODE && cmd[1] == `SMX_CODE_XCHG
    && (cmd[4] == 16'h0000 || cmd[4] > `SMX_WCNT_MAX) |=> err_code == `SMX_ERR_COUNT)
    else $error("write count not checked");
  a_rcnt_range: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == smx_pkg::S_DECODE && cmd[1] == `SMX_CODE_XCHG && cmd[4] == 16'h0001
    && cmd[8] > `SMX_RCNT_MAX |=> err_code == `SMX_ERR_COUNT) else $error("read count not checked");
  a_conn_range: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == smx_pkg::S_DECODE && cmd[1] == `SMX_CODE_CREATE && cmd[3] == `SMX_PROTO_SLAVE
    && cmd[2] > `SMX_CONN_MAX |=> err_code == `SMX_ERR_CONN && $stable(conn_used))
    else $error("bad connection number accepted");
  a_no_store_err: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == smx_pkg::S_WAIT && rx_valid && rx_last && rx_bad
    |=> state == smx_pkg::S_DONE ##1 cmd[0] == `SMX_ERR_REPLY) else $error("bad reply stored");
  a_send_order: assert property (@(posedge pclk) disable iff (!presetn)
    state == smx_pkg::S_WAIT |-> tx_idx == cmd[4][8:0] + 9'h005) else $error("read before write done");
  a_tmo_forever: assert property (@(posedge pclk) disable iff (!presetn)
    cmd[6] == `SMX_TMO_FOREVER |-> !tmo_hit) else $error("infinite timeout expired");

endmodule : smx_top
`default_nettype wire

// *** tb/smx_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module smx_peer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  output logic tx_ready,
  input wire logic rts,
  output logic cts,
  output logic rx_valid,
  output logic [15:0] rx_data,
  output logic rx_last,
  output logic rx_bad,
  input wire logic slow,
  input wire logic bad,
  input wire logic [8:0] rep_n,
  input wire logic [9:0] rep_dly,
  input wire logic [7:0] cts_dly
);
  logic [15:0] frame [8];
  logic [8:0] got;
  logic [8:0] sent;
  logic [9:0] dly;
  logic [7:0] cc;
  logic [7:0] early;
  logic rep_on;
  logic [15:0] cyc;
  // ----------------------------------------
  // reply: remote word at address a reads back a
  // ----------------------------------------
  assign rx_valid = rep_on && dly == 10'h000 && rep_n != 9'h000;
  // idle data keeps moving so a stale word never looks valid
  assign rx_data = rx_valid ? frame[3] + {7'h00, sent} : cyc;
  assign rx_last = rx_valid && sent + 9'h001 == rep_n;
  assign rx_bad = rx_valid && bad && (sent == 9'h000 || rx_last);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      got <= 9'h000;
      sent <= 9'h000;
      dly <= 10'h000;
      rep_on <= 1'b0;
      cyc <= 16'h0000;
      tx_ready <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 16'h0001;
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready)
      begin
        if (got < 9'h008)
          frame[got[2:0]] <= tx_data;
        got <= got + 9'h001;
        // frame is five header words plus the write count
        if (got >= 9'h005 && got - 9'h004 == frame[2][8:0])
        begin
          got <= 9'h000;
          rep_on <= 1'b1;
          sent <= 9'h000;
          dly <= rep_dly;
        end
      end
      else if (rep_on && dly != 10'h000)
        dly <= dly - 10'h001;
      else if (rx_valid)
      begin
        sent <= sent + 9'h001;
        rep_on <= !rx_last;
      end
    end
  end
  // ----------------------------------------
  // modem line
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cc <= 8'h00;
      cts <= 1'b0;
      early <= 8'h00;
    end
    else
    begin
      cc <= rts ? cc + {7'h00, cc != cts_dly} : 8'h00;
      cts <= rts && cc == cts_dly;
      if (tx_valid && rts && !cts)
        early <= early + 8'h01;
    end
  end
endmodule : smx_peer_model
`default_nettype wire

// *** tb/serial_memory_exchange_cmd_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_memory_exchange_cmd_tb;
  localparam int CPS = 20;
  localparam logic [15:0] BAUD [7] = '{16'h012C, 16'h0258, 16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00};
  localparam logic [15:0] HS [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0006};
  localparam logic [15:0] FRM [8] = '{16'h0203, 16'h1234, 16'h0003, 16'h5600, 16'h0004, 16'h1110, 16'h1111,
    16'h1112};
  // {exchange base, word, value, error}
  localparam logic [27:0] ETAB [21] = '{
    {4'h0, 4'h1, 16'h0202, 4'h1}, {4'h0, 4'h3, 16'h0024, 4'h5}, {4'h0, 4'h2, 16'h4B14, 4'h4},
    {4'h0, 4'h2, 16'h4B64, 4'h4}, {4'h0, 4'h2, 16'h4B15, 4'h4}, {4'h0, 4'h4, 16'h0000, 4'h3},
    {4'h0, 4'h4, 16'h0005, 4'h3}, {4'h0, 4'h4, 16'h0004, 4'h3}, {4'h0, 4'h4, 16'h0001, 4'h3},
    {4'h0, 4'h5, 16'h03E8, 4'h5}, {4'h0, 4'h6, 16'h0008, 4'h5}, {4'h0, 4'h7, 16'h0002, 4'h5},
    {4'h0, 4'h8, 16'h0002, 4'h5}, {4'h0, 4'h9, 16'h0003, 4'h5}, {4'h1, 4'h4, 16'h0000, 4'h2},
    {4'h1, 4'h4, 16'h00FF, 4'h2}, {4'h1, 4'h8, 16'h0000, 4'h2}, {4'h1, 4'h8, 16'h0101, 4'h2},
    {4'h1, 4'h2, 16'h4B17, 4'h4}, {4'h1, 4'h1, 16'h0204, 4'h1}, {4'h1, 4'h2, 16'h4B14, 4'h4}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, irq, slow, bad;
  logic tx_valid, tx_ready, rts, cts, rx_valid, rx_last, rx_bad;
  logic [7:0] paddr, cts_dly;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] host_select_setting;
  logic [15:0] tx_data, tx_baud, rx_data;
  logic [15:0] blk [16];
  logic [1:0] tx_port, msk;
  logic [8:0] rep_n;
  logic [9:0] rep_dly;
  int cyc = 0, t_go, t_run, err_count = 0, samples_checked = 0;

  smx_top #(.MEM_AW(8), .CYC_PER_SEC(CPS)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_select_setting(host_select_setting), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_port(tx_port), .tx_baud(tx_baud), .rts(rts), .cts(cts),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_bad(rx_bad), .irq(irq));
  smx_peer_model i_peer (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rts(rts), .cts(cts), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_bad(rx_bad), .slow(slow), .bad(bad), .rep_n(rep_n), .rep_dly(rep_dly), .cts_dly(cts_dly));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      chk("apb ready bound", 32'h1, 32'h0);
      end_of_test();
    end
  endtask : apb

  task automatic mk_create(input logic [15:0] c, p, b, h);
    blk = '{'0, 16'h0001, c, 16'h0023, p, b, 16'h0007, 16'h0001, 16'h0001, h, '0, '0, '0, '0, '0, '0};
  endtask : mk_create

  task automatic mk_xchg(input logic [15:0] c, w, t, s, r, d);
    blk = '{'0, 16'h0203, c, 16'h0010, w, 16'h1234, t, s, r, d, '0, '0, '0, '0, '0, '0};
  endtask : mk_xchg

  task automatic start_cmd();
    blk[0] = '0;
    for (int i = 0; i < 16; i++)
      apb(1'b1, 8'(4 * i), {16'h0000, blk[i]});
    apb(1'b1, 8'h40, 32'h0000_0001);
    t_go = cyc;
  endtask : start_cmd

  task automatic finish_cmd(input logic [3:0] e);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h44, '0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400)
    begin
      chk("busy bound", 32'h1, 32'h0);
      end_of_test();
    end
    t_run = cyc - t_go;
    chk("stat error bit", rd[1], e != 4'h0);
    apb(1'b0, 8'h00, '0);
    chk("error word", rd, {28'h0, e});
    @(negedge pclk);
    chk("irq pin", irq, |(msk & {e != 4'h0, 1'b1}));
    apb(1'b0, 8'h48, '0);
    chk("irq status", rd, {30'h0, e != 4'h0, 1'b1});
    @(negedge pclk);
    chk("irq cleared", irq, 1'b0);
  endtask : finish_cmd

  task automatic rdmem(input logic [7:0] a, input logic [15:0] base, input int n);
    apb(1'b1, 8'h50, {24'h0, a});
    for (int i = 0; i < n; i++)
    begin
      apb(1'b0, 8'h54, '0);
      chk("local memory", rd, {16'h0, base + 16'(i)});
    end
  endtask : rdmem

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    host_select_setting = 4'b0111;
    slow = 1'b0;
    bad = 1'b0;
    rep_n = 9'h004;
    rep_dly = '0;
    cts_dly = 8'h1E;
    msk = 2'b00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("idle outputs", {tx_valid, rts, irq}, 3'b000);
    apb(1'b0, 8'h44, '0);
    chk("stat reset", rd, 32'h0);
    apb(1'b0, 8'h58, '0);
    chk("unmapped error", rerr, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h50, 32'h0000_0010);
    for (int i = 0; i < 3; i++)
      apb(1'b1, 8'h54, 32'h0000_1110 + i);
    apb(1'b1, 8'h4C, 32'h0);
    mk_create(16'h4B15, 16'h0001, 16'h2580, 16'h0000);
    start_cmd();
    finish_cmd(4'h0);
    msk = 2'b11;
    apb(1'b1, 8'h4C, 32'h0000_0003);
    mk_create(16'h4B16, 16'h0002, 16'h12C0, 16'h0006);
    start_cmd();
    finish_cmd(4'h0);
    for (int i = 0; i < 7; i++)
    begin
      mk_create(16'h4B17, 16'h0003, BAUD[i], HS[i % 4]);
      start_cmd();
      finish_cmd(4'h0);
      blk = '{'0, 16'h0002, 16'h4B17, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0};
      start_cmd();
      finish_cmd(4'h0);
    end
    for (int i = 0; i < 21; i++)
    begin
      if (ETAB[i][27:24] == 4'h0)
        mk_create(16'h4B17, 16'h0003, 16'h04B0, '0);
      else
        mk_xchg(16'h4B15, 16'h0001, '0, '0, 16'h0001, 16'h0090);
      blk[ETAB[i][23:20]] = ETAB[i][19:4];
      start_cmd();
      finish_cmd(ETAB[i][3:0]);
    end
    slow = 1'b1;
    mk_xchg(16'h4B15, 16'h0003, '0, 16'h5600, 16'h0004, 16'h0040);
    start_cmd();
    finish_cmd(4'h0);
    for (int k = 0; k < 8; k++)
      chk("sent frame", i_peer.frame[k], FRM[k]);
    rdmem(8'h40, 16'h5600, 4);
    slow = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      bad = i == 0;
      rep_n = (i == 0) ? 9'h004 : 9'h001 + 9'(2 * i);
      mk_xchg(16'h4B15, 16'h0003, '0, 16'h7700, 16'h0004, 16'h0040);
      start_cmd();
      finish_cmd(4'h7);
    end
    bad = 1'b0;
    rdmem(8'h40, 16'h5600, 4);
    rep_n = 9'h100;
    mk_xchg(16'h4B15, 16'h00FE, 16'h0032, 16'h2000, 16'h0100, 16'h0000);
    start_cmd();
    finish_cmd(4'h0);
    rdmem(8'h00, 16'h2000, 1);
    rdmem(8'hFF, 16'h20FF, 1);
    rep_n = '0;
    mk_xchg(16'h4B15, 16'h0001, 16'h0001, 16'h0100, 16'h0001, 16'h0080);
    start_cmd();
    finish_cmd(4'h6);
    chk("one second span", t_run >= 20 && t_run < 40, 1'b1);
    blk[6] = '0;
    start_cmd();
    finish_cmd(4'h6);
    chk("default span", t_run >= 180 && t_run < 200, 1'b1);
    rep_n = 9'h001;
    rep_dly = 10'h258;
    blk[6] = 16'h03E7;
    start_cmd();
    finish_cmd(4'h0);
    rdmem(8'h80, 16'h0100, 1);
    rep_dly = '0;
    rep_n = 9'h002;
    mk_xchg(16'h4B16, 16'h0002, '0, 16'h3000, 16'h0002, 16'h0080);
    start_cmd();
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    chk("modem wait", {rts, tx_valid, tx_port, tx_baud}, {1'b1, 1'b0, 2'd1, 16'h12C0});
    apb(1'b0, 8'h44, '0);
    chk("stat in wait", rd, 32'h0000_0005);
    finish_cmd(4'h0);
    chk("early send", i_peer.early, 8'h00);
    rdmem(8'h80, 16'h3000, 2);
    end_of_test();
  end
endmodule : serial_memory_exchange_cmd_tb
`default_nettype wire
